/* core/tx_drive_pkg.sv */
// package for the transmit line driver and drive monitor block
// assumes a 200 MHz apb clock and a line bit rate derived from it
package tx_drive_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_TX_REDUNDANCY = 16'h1300;
  localparam logic [15:0] IDX_LINE_INT_STATUS = 16'h1302;
  localparam logic [15:0] IDX_LINE_ALARM = 16'h1303;
  localparam logic [15:0] IDX_LINE_TX_CONTROL = 16'h1304;

  // field positions
  localparam int unsigned BIT_DRIVER_ON = 0;
  localparam int unsigned BIT_FAULT = 0;
  localparam int unsigned BIT_FAULT_CHANGE = 0;
  localparam int unsigned BIT_TX_LEVEL = 0;
  localparam int unsigned BIT_ALL_ONES = 2;
  localparam int unsigned BIT_INTERNAL_MON = 5;

  // reset values
  localparam logic [7:0] RST_TX_REDUNDANCY = 8'h01;
  localparam logic [7:0] RST_LINE_TX_CONTROL = 8'h00;

  // writable masks
  localparam logic [7:0] MASK_TX_REDUNDANCY = 8'h01;
  localparam logic [7:0] MASK_LINE_TX_CONTROL = 8'h25;

  // clock cycles per line bit period
  localparam int unsigned LINE_BIT_DIV = 6;
  localparam logic [2:0] LINE_BIT_LAST = 3'(LINE_BIT_DIV - 1);

  // bit periods without a pulse before the fault is declared
  localparam int unsigned FAULT_BITS = 128;
  localparam logic [7:0] FAULT_LAST = 8'(FAULT_BITS - 1);
  localparam logic [7:0] FAULT_FULL = 8'(FAULT_BITS);

  // one bipolar line pair
  typedef struct packed {
    logic pos;
    logic neg;
  } line_pair_t;

  // apb request carrier
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [3:0] strb;
  } apb_req_t;

endpackage

/* core/tx_line_driver_and_drive_monitor.sv */
// transmit line driver enable, all-ones insertion and drive monitor
// assumes apb master on pclk; framer data and monitor pins synchronous
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps

module tx_line_driver_and_drive_monitor
  import tx_drive_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // framer side
  input wire logic tx_data,
  output logic tx_data_take,
  // line pins
  input wire logic line_driver_on,
  output line_pair_t tx_line_out,
  output line_pair_t tx_line_oe,
  input wire line_pair_t monitor_in,
  // status
  output logic drive_monitor_fault,
  output logic irq_n
);

  apb_req_t req;
  logic ack_q;
  logic access;
  logic mapped;
  logic [7:0] rd_byte;
  logic [31:0] prdata_q;
  logic [7:0] redundancy_q;
  logic [7:0] tx_control_q;
  logic fault_change_q;
  logic fault_q;
  logic [7:0] idle_cnt_q;
  logic [2:0] div_q;
  logic bit_en;
  logic polarity_q;
  line_pair_t line_q;
  logic drive_en;
  logic sense_pulse;
  logic fault_set;
  logic fault_clr;
  logic int_read;
  logic send_all_ones;
  logic internal_mon;

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr,
                 wdata: pwdata, strb: pstrb};

  // ---------------- apb slave, one wait state ----------------
  function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
    hit = (a[15:2] == idx[13:0]) && (a[1:0] == 2'b00);
  endfunction

  assign mapped = hit(req.addr, IDX_TX_REDUNDANCY)
               || hit(req.addr, IDX_LINE_INT_STATUS)
               || hit(req.addr, IDX_LINE_ALARM)
               || hit(req.addr, IDX_LINE_TX_CONTROL);

  // pready comes in the second access cycle; writes commit on that edge

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ack_q <= 1'b0;
    else
      ack_q <= req.sel && req.enable && !ack_q;
  end

  assign pready = ack_q;
  assign pslverr = ack_q && !mapped;
  assign access = req.sel && req.enable && ack_q;

  always_comb
  begin
    rd_byte = 8'h00;
    if (hit(req.addr, IDX_TX_REDUNDANCY))
      rd_byte = redundancy_q;
    else if (hit(req.addr, IDX_LINE_INT_STATUS))
      rd_byte = {7'h00, fault_change_q};
    else if (hit(req.addr, IDX_LINE_ALARM))
      rd_byte = {7'h00, fault_q};
    else if (hit(req.addr, IDX_LINE_TX_CONTROL))
      rd_byte = tx_control_q;
  end

  // read data captured in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (req.sel && req.enable && !ack_q && !req.write)
      prdata_q <= {24'h00_0000, rd_byte};
  end

  assign prdata = prdata_q;

  // ---------------- control registers ----------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      redundancy_q <= RST_TX_REDUNDANCY;
    else if (access && req.write && req.strb[0]
             && hit(req.addr, IDX_TX_REDUNDANCY))
      redundancy_q <= req.wdata[7:0] & MASK_TX_REDUNDANCY;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_control_q <= RST_LINE_TX_CONTROL;
    else if (access && req.write && req.strb[0]
             && hit(req.addr, IDX_LINE_TX_CONTROL))
      tx_control_q <= req.wdata[7:0] & MASK_LINE_TX_CONTROL;
  end

  assign send_all_ones = tx_control_q[BIT_ALL_ONES];
  assign internal_mon = tx_control_q[BIT_INTERNAL_MON];

  // ---------------- line bit rate ----------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_q <= 3'h0;
    else if (div_q == LINE_BIT_LAST)
      div_q <= 3'h0;
    else
      div_q <= div_q + 3'h1;
  end

  assign bit_en = (div_q == LINE_BIT_LAST);
  assign tx_data_take = bit_en;

  // ---------------- line driver ----------------
  // the pin gate is combinational so a dropped pin floats the pair at once
  assign drive_en = redundancy_q[BIT_DRIVER_ON] && line_driver_on;

  // marks alternate polarity; all ones overrides framer data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_q <= '0;
      polarity_q <= 1'b0;
    end
    else if (bit_en)
    begin
      if (send_all_ones || tx_data)
      begin
        line_q <= polarity_q ? '{pos: 1'b0, neg: 1'b1}
                             : '{pos: 1'b1, neg: 1'b0};
        polarity_q <= !polarity_q;
      end
      else
        line_q <= '0;
    end
  end

  // off driver floats both pins
  assign tx_line_out = drive_en ? line_q : '0;
  assign tx_line_oe = drive_en ? '{pos: 1'b1, neg: 1'b1} : '0;

  // ---------------- drive monitor ----------------
  // internal mode looks at the pads themselves, external at monitor pins
  always_comb
  begin
    if (internal_mon)
      sense_pulse = tx_line_out.pos || tx_line_out.neg;
    else
      sense_pulse = monitor_in.pos || monitor_in.neg;
  end

  assign fault_set = bit_en && !sense_pulse && !fault_q
                  && (idle_cnt_q == FAULT_LAST);
  assign fault_clr = bit_en && sense_pulse && fault_q;

  // saturates one past the limit so the declare edge is seen only once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idle_cnt_q <= 8'h00;
    else if (bit_en)
    begin
      if (sense_pulse)
        idle_cnt_q <= 8'h00;
      else if (idle_cnt_q != FAULT_FULL)
        idle_cnt_q <= idle_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_q <= 1'b0;
    else if (fault_set)
      fault_q <= 1'b1;
    else if (fault_clr)
      fault_q <= 1'b0;
  end

  assign drive_monitor_fault = fault_q;

  // change flag clears on read; a new change in the same cycle wins
  // only a flag that the read returned is cleared, so a change that lands
  // while the read is in flight survives for the next read
  assign int_read = access && !req.write && prdata_q[BIT_FAULT_CHANGE]
                 && hit(req.addr, IDX_LINE_INT_STATUS);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_change_q <= 1'b0;
    else if (fault_set || fault_clr)
      fault_change_q <= 1'b1;
    else if (int_read)
      fault_change_q <= 1'b0;
  end

  assign irq_n = !fault_change_q;

  // ---------------- assertions ----------------
  a_drive_gate: assert property (@(posedge pclk)
    disable iff (!presetn)
    (tx_line_oe != '0) |-> redundancy_q[BIT_DRIVER_ON] && line_driver_on)
    else $error("line driven without both enables");

  a_write_tristate: assert property (@(posedge pclk)
    disable iff (!presetn)
    access && req.write && req.strb[0] && hit(req.addr, IDX_TX_REDUNDANCY)
    && !req.wdata[BIT_DRIVER_ON] |=> tx_line_oe == '0 && tx_line_out == '0)
    else $error("line not tristated after driver off");

  a_external_src: assert property (@(posedge pclk)
    disable iff (!presetn)
    !internal_mon && bit_en && monitor_in != '0 |=> idle_cnt_q == 8'h00)
    else $error("external mode ignores monitor pins");

  a_internal_src: assert property (@(posedge pclk)
    disable iff (!presetn)
    internal_mon && bit_en && tx_line_out == '0 && idle_cnt_q != FAULT_FULL
    |=> idle_cnt_q == $past(idle_cnt_q) + 8'h01)
    else $error("internal mode not using pads");

  a_fault_delay: assert property (@(posedge pclk)
    disable iff (!presetn)
    $rose(fault_q) |-> $past(idle_cnt_q) == FAULT_LAST
    && idle_cnt_q == FAULT_FULL)
    else $error("fault declared at wrong idle count");

  a_no_early_fault: assert property (@(posedge pclk)
    disable iff (!presetn)
    (idle_cnt_q < FAULT_LAST) |=> !$rose(fault_q))
    else $error("fault while pulses are regular");

  a_status_read: assert property (@(posedge pclk)
    disable iff (!presetn)
    req.sel && req.enable && !ack_q && !req.write
    && hit(req.addr, IDX_LINE_ALARM) |=> prdata[BIT_FAULT] == $past(fault_q))
    else $error("alarm read disagrees with fault");

  a_change_irq: assert property (@(posedge pclk)
    disable iff (!presetn)
    $changed(fault_q) |-> !irq_n && fault_change_q)
    else $error("fault change raised no interrupt");

  a_pulse_clears: assert property (@(posedge pclk)
    disable iff (!presetn)
    fault_q && bit_en && sense_pulse |=> !fault_q && !irq_n)
    else $error("pulse did not clear fault");

  a_count_restart: assert property (@(posedge pclk)
    disable iff (!presetn)
    bit_en && sense_pulse |=> idle_cnt_q == 8'h00)
    else $error("idle count not restarted");

  a_no_repeat: assert property (@(posedge pclk)
    disable iff (!presetn)
    $rose(fault_change_q) |-> $changed(fault_q))
    else $error("interrupt without fault change");

  a_all_ones: assert property (@(posedge pclk)
    disable iff (!presetn)
    bit_en && send_all_ones |=> line_q.pos != line_q.neg)
    else $error("all ones not sent");

endmodule

/* testbench/tx_line_model.sv */
// line model: loops the driven pads back onto the monitor pins
// assumes the design's line pair struct; cut opens the loop
`timescale 1ns/1ps
module tx_line_model
  import tx_drive_pkg::*;
(
  // pads
  input wire line_pair_t drv,
  input wire line_pair_t drv_oe,
  // fault injection
  input wire logic cut,
  // monitor pins
  output line_pair_t mon
);
  // released pads fall to ground through the termination
  assign mon = (drv_oe == 2'b11 && !cut) ? drv : '0;
endmodule

/* testbench/tx_line_driver_and_drive_monitor_test.sv */
// testbench: apb register tests and drive monitor fault sequences
// assumes the line model loops pads to monitor pins
`timescale 1ns/1ps
module tx_line_driver_and_drive_monitor_test;
  import tx_drive_pkg::*;
  localparam logic [15:0] A_DRV = IDX_TX_REDUNDANCY << 2;
  localparam logic [15:0] A_INT = IDX_LINE_INT_STATUS << 2;
  localparam logic [15:0] A_ALM = IDX_LINE_ALARM << 2;
  localparam logic [15:0] A_CTL = IDX_LINE_TX_CONTROL << 2;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic tx_data, take, drv_on, fault, irq_n, cut;
  line_pair_t out, oe, mon;
  int num_errors, total_checks;
  int cnt;
  line_pair_t last_out;

  tx_line_driver_and_drive_monitor i_tx_line_driver_and_drive_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_data(tx_data), .tx_data_take(take), .line_driver_on(drv_on),
    .tx_line_out(out), .tx_line_oe(oe), .monitor_in(mon),
    .drive_monitor_fault(fault), .irq_n(irq_n)
  );
  tx_line_model i_tx_line_model (
    .drv(out), .drv_oe(oe), .cut(cut), .mon(mon)
  );

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    chk({31'h0, pready}, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task bits(input int k);
    repeat (k * 6) @(posedge pclk);
  endtask

  // fault must rise about 128 bit periods after the last pulse
  task wait_fault;
    int n;
    n = 0;
    while (fault !== 1'b1 && n < 1000)
    begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, n >= 125 * 6 && n <= 129 * 6}, 32'h1);
  endtask

  task give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    num_errors = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    tx_data = 1'b1;
    drv_on = 1'b1;
    cut = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(A_DRV, 32'h1);
    rd_chk(A_CTL, 32'h0);
    rd_chk(A_ALM, 32'h0);
    apb(1'b0, 16'h4c04, 32'h0);
    chk({31'h0, er}, 32'h1);
    pstrb <= 4'he;
    apb(1'b1, A_DRV, 32'h0);
    pstrb <= 4'hf;
    rd_chk(A_DRV, 32'h1);
    cnt = 0;
    repeat (60)
    begin
      @(posedge pclk);
      cnt += take;
    end
    chk(cnt, 32'd10);
    $display("test registers done");
    bits(200);
    chk({31'h0, fault}, 32'h0);
    chk({30'h0, oe}, 32'h3);
    chk({31'h0, out.pos ^ out.neg}, 32'h1);
    cut <= 1'b1;
    wait_fault();
    chk({31'h0, irq_n}, 32'h0);
    rd_chk(A_ALM, 32'h1);
    rd_chk(A_INT, 32'h1);
    bits(10);
    chk({31'h0, irq_n}, 32'h1);
    rd_chk(A_INT, 32'h0);
    cut <= 1'b0;
    bits(2);
    chk({31'h0, fault}, 32'h0);
    chk({31'h0, irq_n}, 32'h0);
    rd_chk(A_INT, 32'h1);
    $display("test external monitor done");
    apb(1'b1, A_CTL, 32'hff);
    rd_chk(A_CTL, 32'h25);
    apb(1'b1, A_CTL, 32'h20);
    cut <= 1'b1;
    bits(200);
    chk({31'h0, fault}, 32'h0);
    apb(1'b1, A_DRV, 32'h0);
    bits(1);
    chk({30'h0, oe}, 32'h0);
    chk({30'h0, out}, 32'h0);
    wait_fault();
    rd_chk(A_INT, 32'h1);
    $display("test internal monitor done");
    tx_data <= 1'b0;
    apb(1'b1, A_CTL, 32'h24);
    apb(1'b1, A_DRV, 32'h1);
    bits(3);
    chk({31'h0, fault}, 32'h0);
    rd_chk(A_INT, 32'h1);
    last_out = out;
    bits(1);
    chk({31'h0, out.pos ^ out.neg}, 32'h1);
    chk({30'h0, out}, {30'h0, last_out.neg, last_out.pos});
    apb(1'b1, A_CTL, 32'h0);
    cut <= 1'b0;
    bits(1);
    wait_fault();
    drv_on <= 1'b0;
    bits(1);
    chk({30'h0, oe}, 32'h0);
    chk({30'h0, out}, 32'h0);
    $display("test all ones and pin done");
    give_verdict();
  end
endmodule
